/* plc_special_flag_bank_consts.vh */
`ifndef PLC_SPECIAL_FLAG_BANK_CONSTS_VH
`define PLC_SPECIAL_FLAG_BANK_CONSTS_VH

// ==========================================================================
// Register byte offsets
// ==========================================================================
`define OFS_FLAGS      12'h000
`define OFS_CUR_DATE   12'h004
`define OFS_CUR_TIME   12'h008
`define OFS_NEW_DATE   12'h00c
`define OFS_NEW_TIME   12'h010

// ==========================================================================
// Flag bit positions in the flag register
// ==========================================================================
`define FLAG_W         20
`define B_RUN          0
`define B_SEC_HOLD     1
`define B_ALL_OFF      2
`define B_CARRY        3
`define B_PROG_ERR     4
`define B_LINK_ERR     5
`define B_PROHIBIT     6
`define B_INIT_STOP    7
`define B_LAMP         8
`define B_WR_LOCK      9
`define B_OP_LOCK      10
`define B_CLK_WR_ERR   11
`define B_CLK_RD_ERR   12
`define B_RD_INHIBIT   13
`define B_DATE_CMD     14
`define B_TIME_CMD     15
`define B_DT_CMD       16
`define B_ROUND_CMD    17
`define B_RX1_CANCEL   18
`define B_SEC_PULSE    19

// ==========================================================================
// Reset values, widths and time-field limits
// ==========================================================================
`define FLAGS_RESET    20'h00000
`define OUT_W          108
`define SEC_HALF       8'h1e
`define MIN_WRAP       8'h3c

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_FREQ_KHZ   200000
`define HALF_SEC_MS    500
`define LINK_TIMEOUT_S 10

`endif

/* plc_special_flag_bank.v */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "plc_special_flag_bank_consts.vh"
module plc_special_flag_bank #(
  parameter [31:0] HALF_SEC_CYCLES =
    `HALF_SEC_MS * `CLK_FREQ_KHZ,
  parameter [31:0] LINK_TIMEOUT_CYCLES =
    `LINK_TIMEOUT_S * 1000 * `CLK_FREQ_KHZ
) (
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output reg  [31:0]         prdata,
  output reg                 pready,
  output reg                 pslverr,
  input  wire                backup_run,
  input  wire                backup_prohibit,
  input  wire                cpu_running,
  input  wire                scan_tick,
  input  wire                arith_carry,
  input  wire                shift_carry_valid,
  input  wire                shift_carry_value,
  input  wire                program_error,
  input  wire                link_comm_error,
  input  wire                is_master,
  input  wire                link_frame_ok,
  input  wire [`OUT_W-1:0]   program_outputs,
  input  wire                panel_write_req,
  input  wire                panel_op_req,
  input  wire                cart_present,
  input  wire                cart_read_done,
  input  wire                cart_read_ok,
  input  wire [31:0]         cart_date,
  input  wire [23:0]         cart_time,
  input  wire                cart_write_done,
  input  wire                cart_write_ok,
  output reg                 cpu_halt,
  output reg                 one_second_pulse,
  output reg  [`OUT_W-1:0]   discrete_outputs,
  output reg                 self_hold_clear,
  output reg                 link_stop,
  output reg                 link_reinit,
  output reg                 status_lamp,
  output reg                 panel_write_grant,
  output reg                 panel_op_grant,
  output reg                 cart_date_load,
  output reg                 cart_time_load,
  output reg  [31:0]         cart_new_date,
  output reg  [23:0]         cart_new_time,
  output reg                 port1_receive_cancel
);

  // Stored flags, staging and current-time words, counters and edge memory.
  reg [`FLAG_W-2:0] flags_reg;
  reg [`FLAG_W-2:0] flags_next;
  reg [31:0]        cur_date_reg;
  reg [23:0]        cur_time_reg;
  reg [31:0]        new_date_reg;
  reg [23:0]        new_time_reg;
  reg               init_done_reg;
  reg [3:0]         cmd_seen_reg;
  reg [31:0]        sec_cnt_reg;
  reg [31:0]        link_cnt_reg;
  reg               init_prev_reg;
  reg               sw_wr;
  reg [31:0]        rd_mux;
  reg               rd_err;
  reg [3:0]         cmd_rise;
  reg [7:0]         round_min;

  // Power-up image of the stored flags; bit 19 is the live pulse.
  localparam [`FLAG_W-1:0] FLAGS_RST = `FLAGS_RESET;

  // Acknowledged transfer edge, and the four command flags side by side.
  wire acc = psel & penable & pready;
  wire [3:0] cmd_now = {flags_reg[`B_ROUND_CMD], flags_reg[`B_DT_CMD],
                        flags_reg[`B_TIME_CMD], flags_reg[`B_DATE_CMD]};

  // ========================================================================
  // APB slave
  // ========================================================================

  // Read mux and decode of unmapped addresses.
  always @* begin
    rd_mux = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      `OFS_FLAGS: rd_mux = {12'h000, one_second_pulse, flags_reg};
      `OFS_CUR_DATE: rd_mux = cur_date_reg;
      `OFS_CUR_TIME: rd_mux = {8'h00, cur_time_reg};
      `OFS_NEW_DATE: rd_mux = new_date_reg;
      `OFS_NEW_TIME: rd_mux = {8'h00, new_time_reg};
      default: rd_err = 1'b1;
    endcase
  end

  // One wait state: ready rises in the second access cycle.
  // Read data is captured with ready so that it stands exactly while the
  // master samples it; an unmapped address answers zero with an error.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & rd_err;
      if (psel & penable & ~pready & ~pwrite)
        prdata <= rd_mux;
    end
  end

  // Writes to the date and time staging registers.
  // They change only at the acknowledged edge of a write transfer, so a
  // load command always sees a complete word.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      new_date_reg <= 32'h00000000;
      new_time_reg <= 24'h000000;
    end else if (acc & pwrite) begin
      if (paddr == `OFS_NEW_DATE)
        new_date_reg <= pwdata;
      if (paddr == `OFS_NEW_TIME)
        new_time_reg <= pwdata[23:0];
    end
  end

  // ========================================================================
  // Flag register
  // ========================================================================

  // Software writes first, hardware events after so a set wins a clear.
  // A slave keeps its link stop bit out of software's reach: only the
  // silence timer and a good frame may move it.
  // Bit 19 is the live pulse and is never written.
  always @* begin
    sw_wr = acc & pwrite & (paddr == `OFS_FLAGS);
    flags_next = flags_reg;
    if (sw_wr) begin
      flags_next = pwdata[`FLAG_W-2:0];
      if (!is_master)
        flags_next[`B_INIT_STOP] = flags_reg[`B_INIT_STOP];
    end
    if (!init_done_reg) begin
      flags_next[`B_RUN] = backup_run;
      flags_next[`B_PROHIBIT] = backup_prohibit;
    end
    if (arith_carry)
      flags_next[`B_CARRY] = 1'b1;
    else if (shift_carry_valid)
      flags_next[`B_CARRY] = shift_carry_value;
    if (program_error)
      flags_next[`B_PROG_ERR] = 1'b1;
    if (link_comm_error)
      flags_next[`B_LINK_ERR] = 1'b1;
    if (!is_master) begin
      if (link_frame_ok)
        flags_next[`B_INIT_STOP] = 1'b0;
      else if (link_cnt_reg >= LINK_TIMEOUT_CYCLES - 32'd1)
        flags_next[`B_INIT_STOP] = 1'b1;
    end
    if (cart_write_done)
      flags_next[`B_CLK_WR_ERR] = ~cart_write_ok;
    if (cart_read_done)
      flags_next[`B_CLK_RD_ERR] = ~cart_read_ok;
  end

  // Backup levels are caught in the first clocked cycle after release.
  // The reset branch loads constants only; the retained run and prohibit
  // values come in through flags_next while init_done_reg is still low.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg     <= FLAGS_RST[`FLAG_W-2:0];
      init_done_reg <= 1'b0;
    end else begin
      flags_reg     <= flags_next;
      init_done_reg <= 1'b1;
    end
  end

  // ========================================================================
  // Run control, outputs, lamp, panel, port 1
  // ========================================================================

  // Registered control outputs.
  // Each output follows its flag one clock later, so all of them change
  // together on the edge after a flag write lands.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_halt             <= 1'b0;
      discrete_outputs     <= {`OUT_W{1'b0}};
      self_hold_clear      <= 1'b0;
      status_lamp          <= 1'b0;
      panel_write_grant    <= 1'b0;
      panel_op_grant       <= 1'b0;
      port1_receive_cancel <= 1'b0;
    end else begin
      cpu_halt <= cpu_running & ~flags_reg[`B_RUN];
      discrete_outputs <= flags_reg[`B_ALL_OFF] ? {`OUT_W{1'b0}} :
                          program_outputs;
      // The program must drop its self-hold image while this is high.
      self_hold_clear <= flags_reg[`B_ALL_OFF];
      status_lamp <= flags_reg[`B_LAMP];
      panel_write_grant <= panel_write_req & ~flags_reg[`B_WR_LOCK] &
                           ~flags_reg[`B_OP_LOCK];
      panel_op_grant <= panel_op_req & ~flags_reg[`B_OP_LOCK];
      port1_receive_cancel <= flags_reg[`B_RX1_CANCEL];
    end
  end

  // ========================================================================
  // One-second pulse
  // ========================================================================

  // Half-period counter; hold keeps the pulse low and restarts the phase.
  // After a hold ends the pulse stays low for a full half period, so the
  // first high phase is never cut short.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_cnt_reg      <= 32'h00000000;
      one_second_pulse <= 1'b0;
    end else if (flags_reg[`B_SEC_HOLD]) begin
      sec_cnt_reg      <= 32'h00000000;
      one_second_pulse <= 1'b0;
    end else if (sec_cnt_reg >= HALF_SEC_CYCLES - 32'd1) begin
      sec_cnt_reg      <= 32'h00000000;
      one_second_pulse <= ~one_second_pulse;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'd1;
    end
  end

  // ========================================================================
  // Data link
  // ========================================================================

  // Silence timer for the slave and reinit pulse for the master.
  // The timer saturates one short of its limit, so a long silence keeps
  // the stop condition asserted instead of wrapping round.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cnt_reg  <= 32'h00000000;
      init_prev_reg <= 1'b0;
      link_reinit   <= 1'b0;
      link_stop     <= 1'b0;
    end else begin
      if (is_master | link_frame_ok)
        link_cnt_reg <= 32'h00000000;
      else if (link_cnt_reg < LINK_TIMEOUT_CYCLES - 32'd1)
        link_cnt_reg <= link_cnt_reg + 32'd1;
      init_prev_reg <= flags_reg[`B_INIT_STOP];
      link_reinit <= is_master & flags_reg[`B_INIT_STOP] &
                     ~init_prev_reg;
      link_stop <= is_master ? flags_reg[`B_PROHIBIT] :
                   flags_reg[`B_INIT_STOP];
    end
  end

  // ========================================================================
  // Calendar clock cartridge
  // ========================================================================

  // Rising edges of the four command flags, judged at scan boundaries.
  // Minutes wrap from 59 to 0 with no carry into the hour; a user who
  // needs the hour carry must set the hour by a full time load.
  always @* begin
    cmd_rise  = cmd_now & ~cmd_seen_reg;
    round_min = cur_time_reg[15:8] + 8'h01;
    if (round_min >= `MIN_WRAP)
      round_min = 8'h00;
  end

  // Current-time copy, command edge memory and cartridge load strobes.
  // A combined load takes priority over rounding in the same scan, and a
  // flag left set repeats nothing until it has been seen low at a tick.
  // Strobes last one clock; the staged words stand until the next load.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_date_reg   <= 32'h00000000;
      cur_time_reg   <= 24'h000000;
      cmd_seen_reg   <= 4'h0;
      cart_date_load <= 1'b0;
      cart_time_load <= 1'b0;
      cart_new_date  <= 32'h00000000;
      cart_new_time  <= 24'h000000;
    end else begin
      if (cart_present & cart_read_done & cart_read_ok &
          ~(cpu_running & flags_reg[`B_RD_INHIBIT])) begin
        cur_date_reg <= cart_date;
        cur_time_reg <= cart_time;
      end
      cart_date_load <= 1'b0;
      cart_time_load <= 1'b0;
      if (scan_tick) begin
        cmd_seen_reg <= cmd_now;
        if (cmd_rise[0] | cmd_rise[2]) begin
          cart_date_load <= 1'b1;
          cart_new_date  <= new_date_reg;
        end
        if (cmd_rise[1] | cmd_rise[2]) begin
          cart_time_load <= 1'b1;
          cart_new_time  <= new_time_reg;
        end else if (cmd_rise[3]) begin
          cart_time_load <= 1'b1;
          if (cur_time_reg[7:0] < `SEC_HALF)
            cart_new_time <= {cur_time_reg[23:8], 8'h00};
          else
            cart_new_time <= {cur_time_reg[23:16], round_min,
                              8'h00};
        end
      end
    end
  end

endmodule

/* plc_special_flag_bank_props.sv */
`timescale 1ns/1ps
`include "plc_special_flag_bank_consts.vh"
// ==================================================
// Port checker for the flag bank.
module plc_special_flag_bank_props #(
  parameter [31:0] HALF_SEC_CYCLES     = 32'h0000000a,
  parameter [31:0] LINK_TIMEOUT_CYCLES = 32'h00000014
) (
  input logic              pclk,
  input logic              presetn,
  input logic              psel,
  input logic              penable,
  input logic              pready,
  input logic              cpu_running,
  input logic              cpu_halt,
  input logic              scan_tick,
  input logic              is_master,
  input logic              link_frame_ok,
  input logic              link_stop,
  input logic              link_reinit,
  input logic              one_second_pulse,
  input logic [`OUT_W-1:0] discrete_outputs,
  input logic              self_hold_clear,
  input logic              cart_date_load,
  input logic              cart_time_load,
  input logic              panel_write_req,
  input logic              panel_write_grant
);
  int hi_cnt;
  int quiet_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Count how long the pulse stays high and how long a slave hears nothing.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_cnt    <= 0;
      quiet_cnt <= 0;
    end else begin
      hi_cnt    <= one_second_pulse ? hi_cnt + 1 : 0;
      quiet_cnt <= (is_master || link_frame_ok) ? 0 : quiet_cnt + 1;
    end
  end
  chk_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  chk_apb_only: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  chk_halt_cause: assert property (cpu_halt |-> $past(cpu_running))
    else $error("halt without running");
  chk_off_blank: assert property (
    self_hold_clear && $past(self_hold_clear) |-> discrete_outputs == '0)
    else $error("outputs live while all off");
  chk_pulse_high: assert property (hi_cnt <= HALF_SEC_CYCLES)
    else $error("second pulse high too long");
  chk_load_tick: assert property (
    $rose(cart_date_load) |-> $past(scan_tick))
    else $error("date load not after scan tick");
  chk_load_once: assert property (cart_time_load |=> !cart_time_load)
    else $error("time load longer than a cycle");
  chk_reinit_master: assert property (link_reinit |-> is_master)
    else $error("reinit at a slave");
  chk_stop_clear: assert property (
    !is_master && link_frame_ok |-> ##2 !link_stop)
    else $error("stop flag kept after good frame");
  chk_stop_quiet: assert property (
    quiet_cnt > LINK_TIMEOUT_CYCLES + 3 |-> link_stop)
    else $error("stop flag missing after silence");
  chk_grant_req: assert property (
    panel_write_grant |-> $past(panel_write_req))
    else $error("grant without request");
  cover property ($rose(cart_date_load));
  cover property (link_reinit);
  cover property ($fell(one_second_pulse));
endmodule

bind plc_special_flag_bank plc_special_flag_bank_props #(
  .HALF_SEC_CYCLES(HALF_SEC_CYCLES),
  .LINK_TIMEOUT_CYCLES(LINK_TIMEOUT_CYCLES)
) plc_special_flag_bank_props_inst (.pclk, .presetn, .psel, .penable,
  .pready, .cpu_running, .cpu_halt, .scan_tick, .is_master, .link_frame_ok,
  .link_stop, .link_reinit, .one_second_pulse, .discrete_outputs,
  .self_hold_clear, .cart_date_load, .cart_time_load, .panel_write_req,
  .panel_write_grant);

/* clock_cartridge_model.sv */
`timescale 1ns/1ps
// ==================================================
// Calendar clock cartridge standing behind the bank.
module clock_cartridge_model (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        cart_date_load,
  input  logic        cart_time_load,
  input  logic [31:0] cart_new_date,
  input  logic [23:0] cart_new_time,
  input  logic        read_req,
  input  logic        fail_wr,
  input  logic        fail_rd,
  input  logic        slow,
  output logic        cart_read_done,
  output logic        cart_read_ok,
  output logic [31:0] cart_date,
  output logic [23:0] cart_time,
  output logic        cart_write_done,
  output logic        cart_write_ok
);
  logic [31:0] date_q;
  logic [23:0] time_q;
  logic [3:0]  wr_dly;
  logic        wr_end;
  // Slow mode answers a write three cycles later than prompt mode.
  assign wr_end = slow ? wr_dly[3] : wr_dly[0];
  // Store loads, answer writes, and scramble data outside a read.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {date_q, time_q, wr_dly} <= '0;
      {cart_read_done, cart_read_ok, cart_write_done} <= 3'h0;
      {cart_write_ok, cart_date, cart_time} <= '0;
    end else begin
      cart_read_done  <= read_req;
      cart_read_ok    <= read_req & ~fail_rd;
      cart_date       <= read_req ? date_q : ~cart_date;
      cart_time       <= read_req ? time_q : ~cart_time;
      if (cart_date_load) date_q <= cart_new_date;
      if (cart_time_load) time_q <= cart_new_time;
      wr_dly          <= {wr_dly[2:0], cart_date_load | cart_time_load};
      cart_write_done <= wr_end;
      cart_write_ok   <= wr_end & ~fail_wr;
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "plc_special_flag_bank_consts.vh"
// ==================================================
// Self-checking bench for the flag bank.
module tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, cart_date, cart_new_date;
  logic [23:0] cart_time, cart_new_time;
  logic [7:0]  cnt;
  logic        backup_run, backup_prohibit, cpu_running, scan_tick;
  logic        arith_carry, shift_carry_valid, shift_carry_value;
  logic        program_error, link_comm_error, is_master, link_frame_ok;
  logic        panel_write_req, panel_op_req, cart_present, cart_read_done;
  logic        cart_read_ok, cart_write_done, cart_write_ok, cpu_halt;
  logic        one_second_pulse, self_hold_clear, link_stop, link_reinit;
  logic        status_lamp, panel_write_grant, panel_op_grant;
  logic        cart_date_load, cart_time_load, port1_receive_cancel;
  logic        read_req, fail_wr, fail_rd, slow;
  logic [`OUT_W-1:0] program_outputs, discrete_outputs;
  int          err_total, checked, n_dl, n_tl, n_ri;
  plc_special_flag_bank #(.HALF_SEC_CYCLES(32'h0000000a),
    .LINK_TIMEOUT_CYCLES(32'h00000014)) plc_special_flag_bank_inst (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .backup_run, .backup_prohibit, .cpu_running, .scan_tick,
    .arith_carry, .shift_carry_valid, .shift_carry_value, .program_error,
    .link_comm_error, .is_master, .link_frame_ok, .program_outputs,
    .panel_write_req, .panel_op_req, .cart_present, .cart_read_done,
    .cart_read_ok, .cart_date, .cart_time, .cart_write_done, .cart_write_ok,
    .cpu_halt, .one_second_pulse, .discrete_outputs, .self_hold_clear,
    .link_stop, .link_reinit, .status_lamp, .panel_write_grant,
    .panel_op_grant, .cart_date_load, .cart_time_load, .cart_new_date,
    .cart_new_time, .port1_receive_cancel);
  clock_cartridge_model clock_cartridge_model_inst (.pclk, .presetn,
    .cart_date_load, .cart_time_load, .cart_new_date, .cart_new_time,
    .read_req, .fail_wr, .fail_rd, .slow, .cart_read_done, .cart_read_ok,
    .cart_date, .cart_time, .cart_write_done, .cart_write_ok);
  // Make the clock and count pulses leaving the bank.
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (cart_date_load === 1'h1) n_dl++;
    if (cart_time_load === 1'h1) n_tl++;
    if (link_reinit === 1'h1) n_ri++;
  end
  // ==================================================
  // Shared tasks.
  task chk(input logic [127:0] g, input logic [127:0] e);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task print_verdict;
    $display("checked=%0d errors=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
    if (n == 16) begin
      err_total++;
      print_verdict;
    end
  endtask
  task waitn(input int k);
    repeat (k) @(posedge pclk);
  endtask
  task tick;
    @(posedge pclk) scan_tick <= 1'h1;
    @(posedge pclk) scan_tick <= 1'h0;
    waitn(10);
  endtask
  task cart_read;
    @(posedge pclk) read_req <= 1'h1;
    @(posedge pclk) read_req <= 1'h0;
    waitn(4);
  endtask
  // ==================================================
  // Scenarios.
  task t_reset;
    apb(0, `OFS_FLAGS, 0);
    chk(rd[18:0], 19'h00041);
    chk(link_stop, 1'h1);
    chk({panel_write_grant, panel_op_grant}, 2'h3);
    apb(0, 12'h014, 0);
    chk({er, rd}, {1'h1, 32'h0});
    @(posedge pclk) cpu_running <= 1'h1;
    apb(1, `OFS_FLAGS, 0);
    waitn(2);
    chk({cpu_halt, link_stop}, 2'h2);
    apb(1, `OFS_FLAGS, 1);
    waitn(2);
    chk(cpu_halt, 1'h0);
    $display("end t_reset");
  endtask
  task t_outputs;
    apb(1, `OFS_FLAGS, 32'h00040107);
    waitn(2);
    chk(discrete_outputs, '0);
    chk(self_hold_clear, 1'h1);
    chk({status_lamp, port1_receive_cancel}, 2'h3);
    cnt = 0;
    repeat (30) @(posedge pclk) cnt += one_second_pulse;
    chk(cnt, 8'h00);
    apb(1, `OFS_FLAGS, 1);
    waitn(2);
    chk(discrete_outputs, program_outputs);
    chk({status_lamp, port1_receive_cancel}, 2'h0);
    cnt = 0;
    repeat (40) @(posedge pclk) cnt += one_second_pulse;
    chk(cnt, 8'h14);
    $display("end t_outputs");
  endtask
  task t_sticky;
    @(posedge pclk) {arith_carry, program_error, link_comm_error} <= 3'h7;
    @(posedge pclk) {arith_carry, program_error, link_comm_error} <= 3'h0;
    waitn(5);
    apb(0, `OFS_FLAGS, 0);
    chk(rd[5:3], 3'h7);
    @(posedge pclk) shift_carry_valid <= 1'h1;
    @(posedge pclk) shift_carry_valid <= 1'h0;
    apb(0, `OFS_FLAGS, 0);
    chk(rd[5:3], 3'h6);
    apb(1, `OFS_FLAGS, 1);
    apb(0, `OFS_FLAGS, 0);
    chk(rd[5:3], 3'h0);
    @(posedge pclk) {shift_carry_valid, shift_carry_value} <= 2'h3;
    @(posedge pclk) shift_carry_valid <= 1'h0;
    apb(0, `OFS_FLAGS, 0);
    chk(rd[3], 1'h1);
    $display("end t_sticky");
  endtask
  task t_clock;
    apb(1, `OFS_NEW_DATE, 32'h11223344);
    apb(1, `OFS_NEW_TIME, 32'h00033b2d);
    apb(1, `OFS_FLAGS, 32'h00010001);
    tick;
    tick;
    chk({n_dl[7:0], n_tl[7:0]}, 16'h0101);
    chk({cart_new_date, cart_new_time}, 56'h11223344033b2d);
    cart_read;
    apb(0, `OFS_CUR_TIME, 0);
    chk(rd, 32'h00033b2d);
    apb(0, `OFS_FLAGS, 0);
    chk(rd[12:11], 2'h0);
    apb(1, `OFS_FLAGS, 32'h00030001);
    tick;
    chk(cart_new_time, 24'h030000);
    chk({n_dl[7:0], n_tl[7:0]}, 16'h0102);
    apb(1, `OFS_FLAGS, 32'h00002001);
    cart_read;
    apb(0, `OFS_CUR_TIME, 0);
    chk(rd, 32'h00033b2d);
    @(posedge pclk) {cpu_running, cart_present} <= 2'h0;
    cart_read;
    apb(0, `OFS_CUR_TIME, 0);
    chk(rd, 32'h00033b2d);
    @(posedge pclk) cart_present <= 1'h1;
    cart_read;
    apb(0, `OFS_CUR_TIME, 0);
    chk(rd, 32'h00030000);
    @(posedge pclk) {cpu_running, fail_wr, fail_rd, slow} <= 4'hf;
    apb(1, `OFS_FLAGS, 32'h00004001);
    tick;
    cart_read;
    apb(0, `OFS_FLAGS, 0);
    chk(rd[12:11], 2'h3);
    chk(n_dl[7:0], 8'h02);
    $display("end t_clock");
  endtask
  task t_link;
    apb(1, `OFS_FLAGS, 32'h00000081);
    waitn(3);
    chk(n_ri[7:0], 8'h01);
    apb(1, `OFS_FLAGS, 32'h00000201);
    waitn(2);
    chk({panel_write_grant, panel_op_grant}, 2'h1);
    apb(1, `OFS_FLAGS, 32'h00000401);
    waitn(2);
    chk({panel_write_grant, panel_op_grant}, 2'h0);
    @(posedge pclk) is_master <= 1'h0;
    waitn(30);
    chk(link_stop, 1'h1);
    @(posedge pclk) link_frame_ok <= 1'h1;
    @(posedge pclk) link_frame_ok <= 1'h0;
    waitn(2);
    chk(link_stop, 1'h0);
    $display("end t_link");
  endtask
  task t_power;
    @(posedge pclk) {link_comm_error, is_master, backup_run} <= 3'h6;
    @(posedge pclk) {link_comm_error, presetn} <= 2'h0;
    waitn(2);
    presetn <= 1'h1;
    apb(0, `OFS_FLAGS, 0);
    chk(rd[18:0], 19'h00040);
    chk({cpu_halt, link_stop}, 2'h3);
    $display("end t_power");
  endtask
  // Reset, run the scenarios, then report.
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, cpu_running} = '0;
    {scan_tick, arith_carry, shift_carry_valid, shift_carry_value} = '0;
    {program_error, link_comm_error, link_frame_ok, read_req} = '0;
    {fail_wr, fail_rd, slow, err_total, checked, n_dl, n_tl, n_ri} = '0;
    {backup_run, backup_prohibit, is_master, cart_present} = 4'hf;
    {panel_write_req, panel_op_req} = 2'h3;
    program_outputs = {27{4'ha}};
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    t_reset;
    t_outputs;
    t_sticky;
    t_clock;
    t_link;
    t_power;
    print_verdict;
  end
  // Cut a hung run short.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    print_verdict;
  end
endmodule
